// [inc/bitbang_pkg.sv]
// Constants and types shared by the bit-bang parallel port
package bitbang_pkg;
   localparam int unsigned BUS_W = 8;
   localparam int unsigned BUF_DEPTH = 2;
   localparam logic [7:0] BUS_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   // Write strobe low time
   localparam int unsigned WR_STROBE_NS = 40;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam logic [3:0] WR_STROBE_CYC = 4'((WR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Bus usage of one channel
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ASYNC = 2'b01,
      MODE_SYNC = 2'b10
   } bb_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WSTROBE = 2'b01,
      ST_SAMPLE = 2'b10
   } bb_state_t;
endpackage : bitbang_pkg

// [src/bitbang_parallel_port.sv]
// One channel of the bit-bang parallel port with its wakeup/send-now input
//
// Behaviour
// - In a bit-bang mode the eight channel lines form one bidirectional 8-bit bus, bit 7 down to bit 0.
// - Synchronous and asynchronous bit-bang are selectable per channel; one instance serves one channel.
// - The active-low write strobe pulses low starting in the same cycle a host byte is placed on the pins.
// - The read strobe rises once the pin value has been sampled and passed toward the host.
// - While suspended with remote wakeup enabled, a low pulse on send-now/wake requests a USB resume.
// - In normal operation a low pulse on send-now/wake flushes the transmit buffer on the next bulk IN.
`timescale 1ns/100ps
`default_nettype none
module bitbang_parallel_port (
   input wire logic clk,
   input wire logic resetn,
   input wire bitbang_pkg::bb_mode_t mode,
   input wire logic [7:0] pin_dir,
   // Host bytes toward the pins
   input wire logic [7:0] host_data,
   input wire logic host_valid,
   output logic host_ready,
   // Sampled bytes toward the host
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   // Parallel pins, enable active low
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic [7:0] bus_oe_n,
   output logic pin_write_strobe_n,
   output logic pin_read_strobe_n,
   input wire logic send_now_wake_n,
   input wire logic usb_active_n,
   input wire logic remote_wake_en,
   output logic resume_req,
   output logic flush_req
);
   // Two-entry input buffer for host bytes
   logic [7:0] buf_mem_q [0:1];
   logic [7:0] buf_mem_d [0:1];
   logic buf_wp_q;
   logic buf_wp_d;
   logic buf_rp_q;
   logic buf_rp_d;
   logic [1:0] buf_cnt_q;
   logic [1:0] buf_cnt_d;
   logic buf_pop;
   // Transfer engine: held pin byte, sample, strobes and strobe timer
   logic [7:0] out_q;
   logic [7:0] out_d;
   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic rxv_q;
   logic rxv_d;
   logic wrs_n_q;
   logic wrs_n_d;
   logic rds_n_q;
   logic rds_n_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   bitbang_pkg::bb_state_t st_q;
   bitbang_pkg::bb_state_t st_d;
   // Wake synchroniser and request pulses
   logic sw_s1_q;
   logic sw_s1_d;
   logic sw_s2_q;
   logic sw_s2_d;
   logic sw_s3_q;
   logic sw_s3_d;
   logic res_q;
   logic res_d;
   logic fl_q;
   logic fl_d;
   // Derived handshakes
   logic active;
   logic push;
   logic wake_pulse;

   assign active = (mode != bitbang_pkg::MODE_OFF);
   assign host_ready = active && (buf_cnt_q != 2'(bitbang_pkg::BUF_DEPTH));
   assign push = host_valid && host_ready;
   assign rx_valid = rxv_q;
   assign rx_data = rx_q;
   assign bus_out = out_q;
   // In a bit-bang mode lines set as outputs drive the held host byte; all other lines are inputs
   assign bus_oe_n = active ? ~pin_dir : 8'hFF;
   assign pin_write_strobe_n = wrs_n_q;
   assign pin_read_strobe_n = rds_n_q;
   assign resume_req = res_q;
   assign flush_req = fl_q;
   // Rising edge of the synchronised input marks a finished low pulse
   assign wake_pulse = sw_s2_q && !sw_s3_q;

   // Buffer pointers and storage
   always_comb begin
      buf_mem_d[0] = buf_mem_q[0];
      buf_mem_d[1] = buf_mem_q[1];
      buf_wp_d = buf_wp_q;
      buf_rp_d = buf_rp_q;
      if (push) begin
         buf_mem_d[buf_wp_q] = host_data;
         buf_wp_d = ~buf_wp_q;
      end
      if (buf_pop) begin
         buf_rp_d = ~buf_rp_q;
      end
      buf_cnt_d = buf_cnt_q + 2'(push) - 2'(buf_pop);
   end

   // Transfer engine: write a byte then sample in sync mode; write only, or sample only, in async mode
   always_comb begin
      st_d = st_q;
      out_d = out_q;
      rx_d = rx_q;
      rxv_d = rxv_q && !rx_ready;
      wrs_n_d = 1'b1;
      rds_n_d = rds_n_q;
      cnt_d = cnt_q;
      buf_pop = 1'b0;
      case (st_q)
         bitbang_pkg::ST_IDLE: begin
            if (active && buf_cnt_q != 2'b00) begin
               out_d = buf_mem_q[buf_rp_q];
               buf_pop = 1'b1;
               wrs_n_d = 1'b0;
               cnt_d = bitbang_pkg::WR_STROBE_CYC;
               st_d = bitbang_pkg::ST_WSTROBE;
            end else if (mode == bitbang_pkg::MODE_ASYNC && !rxv_d) begin
               // Asynchronous form samples freely when the host can take it
               rds_n_d = 1'b0;
               st_d = bitbang_pkg::ST_SAMPLE;
            end
         end
         bitbang_pkg::ST_WSTROBE: begin
            wrs_n_d = (cnt_q == 4'h1);
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               // Synchronous form samples after every write
               st_d = (mode == bitbang_pkg::MODE_SYNC) ? bitbang_pkg::ST_SAMPLE : bitbang_pkg::ST_IDLE;
               rds_n_d = (mode != bitbang_pkg::MODE_SYNC);
            end
         end
         bitbang_pkg::ST_SAMPLE: begin
            // Waits while the previous sample is unread, so nothing is lost
            if (!rxv_d) begin
               rx_d = bus_in;
               rxv_d = 1'b1;
               rds_n_d = 1'b1;
               st_d = bitbang_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d = bitbang_pkg::ST_IDLE;
            rds_n_d = 1'b1;
         end
      endcase
   end

   // Wake synchroniser and request pulses, one cycle per completed low pulse
   always_comb begin
      // Two flops against metastability; the third only remembers the last level
      sw_s1_d = send_now_wake_n;
      sw_s2_d = sw_s1_q;
      sw_s3_d = sw_s2_q;
      // Suspended: resume only when remote wakeup is allowed
      res_d = wake_pulse && usb_active_n && remote_wake_en;
      // Running: push out whatever is held, whatever its size
      fl_d = wake_pulse && !usb_active_n;
   end

   // Host byte buffer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         buf_mem_q[0] <= bitbang_pkg::BUS_RESET;
         buf_mem_q[1] <= bitbang_pkg::BUS_RESET;
         buf_wp_q <= 1'b0;
         buf_rp_q <= 1'b0;
         buf_cnt_q <= 2'b00;
      end else begin
         buf_mem_q[0] <= buf_mem_d[0];
         buf_mem_q[1] <= buf_mem_d[1];
         buf_wp_q <= buf_wp_d;
         buf_rp_q <= buf_rp_d;
         buf_cnt_q <= buf_cnt_d;
      end
   end

   // Transfer engine registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= bitbang_pkg::ST_IDLE;
         out_q <= bitbang_pkg::BUS_RESET;
         rx_q <= bitbang_pkg::BUS_RESET;
         rxv_q <= 1'b0;
         wrs_n_q <= 1'b1;
         rds_n_q <= 1'b1;
         cnt_q <= 4'h0;
      end else begin
         st_q <= st_d;
         out_q <= out_d;
         rx_q <= rx_d;
         rxv_q <= rxv_d;
         wrs_n_q <= wrs_n_d;
         rds_n_q <= rds_n_d;
         cnt_q <= cnt_d;
      end
   end

   // Wake registers; synchroniser flops idle high after reset so no false edge follows it, request pulses reset low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sw_s1_q <= 1'b1;
         sw_s2_q <= 1'b1;
         sw_s3_q <= 1'b1;
         res_q <= 1'b0;
         fl_q <= 1'b0;
      end else begin
         sw_s1_q <= sw_s1_d;
         sw_s2_q <= sw_s2_d;
         sw_s3_q <= sw_s3_d;
         res_q <= res_d;
         fl_q <= fl_d;
      end
   end
endmodule : bitbang_parallel_port
`default_nettype wire

// [verification/bitbang_parallel_port_assertions.sv]
// Checker for the bit-bang port outputs
`timescale 1ns/100ps
`default_nettype none
module bb_port_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic host_ready,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic pin_write_strobe_n,
   input wire logic pin_read_strobe_n,
   input wire logic send_now_wake_n,
   input wire logic usb_active_n,
   input wire logic remote_wake_en,
   input wire logic resume_req,
   input wire logic flush_req,
   input wire bitbang_pkg::bb_mode_t mode,
   input wire logic [7:0] pin_dir,
   input wire logic [7:0] bus_out,
   input wire logic [7:0] bus_oe_n,
   input wire logic [7:0] rx_data
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // Wake acts on the end of the low pulse, so a held-low input does nothing
   sequence wake_end;
      $rose(send_now_wake_n);
   endsequence
   a_oe_follows_dir: assert property (bus_oe_n == (mode == bitbang_pkg::MODE_OFF ? 8'hFF : ~pin_dir))
      else $error("oe");
   a_refuse_off: assert property (mode == bitbang_pkg::MODE_OFF |-> !host_ready) else $error("ready");
   a_wr_width: assert property ($fell(pin_write_strobe_n) |=> !pin_write_strobe_n ##1 pin_write_strobe_n)
      else $error("wr");
   a_wr_data_held: assert property ($fell(pin_write_strobe_n) |=> $stable(bus_out)) else $error("bus");
   // The read strobe rises only as a sample is taken, so rx_valid is high with it
   a_rd_rise: assert property ($rose(pin_read_strobe_n) |-> rx_valid) else $error("rd");
   a_rd_sample: assert property (!pin_read_strobe_n && !(rx_valid && !rx_ready) |=> pin_read_strobe_n && rx_valid)
      else $error("sample");
   a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("rx");
   a_wake_resume: assert property (wake_end ##0 (usb_active_n && remote_wake_en) |-> ##[3:5] resume_req)
      else $error("resume");
   a_wake_flush: assert property (wake_end ##0 !usb_active_n |-> ##[3:5] flush_req) else $error("flush");
   a_req_once: assert property (flush_req || resume_req |=> !flush_req && !resume_req) else $error("once");
endmodule : bb_port_chk
bind bitbang_parallel_port bb_port_chk chk (.*);
`default_nettype wire

// [verification/pin_logic_model.sv]
// External logic on the parallel pins
`timescale 1ns/100ps
`default_nettype none
module pin_logic_model (
   input wire logic [7:0] bus_out,
   input wire logic [7:0] bus_oe_n,
   input wire logic [7:0] ext,
   output logic [7:0] bus_in
);
   // A line shows the port where it drives, else the far side's level
   assign bus_in = (bus_out & ~bus_oe_n) | (ext & bus_oe_n);
endmodule : pin_logic_model
`default_nettype wire

// [verification/bitbang_parallel_port_test.sv]
// Self-checking bench for the bit-bang port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, a, e); end end
module bitbang_parallel_port_test;
   logic clk, resetn, host_valid, host_ready, rx_valid, pin_write_strobe_n, pin_read_strobe_n;
   logic send_now_wake_n, usb_active_n, remote_wake_en, resume_req, flush_req;
   logic rx_ready = 1'b0;
   logic [7:0] pin_dir, host_data, bus_in, bus_out, bus_oe_n, rx_data, ext, lastb, aexp;
   logic [7:0] wq[$], rq[$];
   bitbang_pkg::bb_mode_t mode;
   int n_mismatch, comparisons, cyc, n_fl, n_rs;
   int seed = 32'hB61D61E0;
   bitbang_parallel_port DUT (
      .clk(clk),
      .resetn(resetn),
      .mode(mode),
      .pin_dir(pin_dir),
      .host_data(host_data),
      .host_valid(host_valid),
      .host_ready(host_ready),
      .rx_data(rx_data),
      .rx_valid(rx_valid),
      .rx_ready(rx_ready),
      .bus_in(bus_in),
      .bus_out(bus_out),
      .bus_oe_n(bus_oe_n),
      .pin_write_strobe_n(pin_write_strobe_n),
      .pin_read_strobe_n(pin_read_strobe_n),
      .send_now_wake_n(send_now_wake_n),
      .usb_active_n(usb_active_n),
      .remote_wake_en(remote_wake_en),
      .resume_req(resume_req),
      .flush_req(flush_req)
   );
   pin_logic_model far (
      .bus_out(bus_out),
      .bus_oe_n(bus_oe_n),
      .ext(ext),
      .bus_in(bus_in)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   // Hold the byte until ready is seen high at an edge
   task automatic put(input logic [7:0] d);
      host_data <= d;
      host_valid <= 1'b1;
      wq.push_back(d);
      rq.push_back((d & pin_dir) | (ext & ~pin_dir));
      lastb = d;
      @(posedge clk);
      while (host_ready !== 1'b1) @(posedge clk);
   endtask : put
   task automatic wake;
      send_now_wake_n <= 1'b0;
      repeat (3) @(posedge clk);
      send_now_wake_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : wake
   // Scoreboard and random receiver stalls; a stall must lose no sample
   always @(posedge clk) begin
      cyc++;
      if (flush_req === 1'b1) n_fl++;
      if (resume_req === 1'b1) n_rs++;
      if ($fell(pin_write_strobe_n)) `CHK(bus_out, wq.pop_front())
      if (rx_valid === 1'b1 && rx_ready === 1'b1 && mode == bitbang_pkg::MODE_SYNC) `CHK(rx_data, rq.pop_front())
      else if (rx_valid === 1'b1 && rx_ready === 1'b1) `CHK(rx_data, aexp)
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
      rx_ready <= 1'($random(seed));
   end
   initial begin
      resetn = 1'b0;
      mode = bitbang_pkg::MODE_OFF;
      {pin_dir, host_data, ext} = 24'h000000;
      host_valid = 1'b0;
      {send_now_wake_n, usb_active_n, remote_wake_en} = 3'b101;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      `CHK(host_ready, 1'b0)
      pin_dir <= 8'($random(seed));
      ext <= 8'($random(seed));
      mode <= bitbang_pkg::MODE_SYNC;
      @(posedge clk);
      `CHK(bus_oe_n, ~pin_dir)
      for (int i = 0; i < 8; i++) put(i == 0 ? 8'hFF : 8'($random(seed)));
      host_valid <= 1'b0;
      repeat (200) @(posedge clk);
      aexp = (lastb & pin_dir) | (ext & ~pin_dir);
      mode <= bitbang_pkg::MODE_ASYNC;
      repeat (40) @(posedge clk);
      // Async write of the same byte keeps the expected sample unchanged
      put(lastb);
      host_valid <= 1'b0;
      repeat (20) @(posedge clk);
      wake();
      usb_active_n <= 1'b1;
      wake();
      remote_wake_en <= 1'b0;
      wake();
      `CHK(n_fl, 1)
      `CHK(n_rs, 1)
      end_of_test();
   end
endmodule : bitbang_parallel_port_test
`default_nettype wire
